/* verilog/cmrd_pkg.sv */
// package: constants and types for the clock mode ratio decoder
package cmrd_pkg;
  // factors are held in half units: value 5 means 2.5
  localparam int          FACTOR_W        = 5;
  localparam int          MODE_W          = 7;
  localparam int          NIBBLE_LSB      = 28;
  localparam int          NIBBLE_MSB      = 31;
  localparam int          CFG_WORD_W      = 32;
  localparam logic [6:0]  MODE_RESET      = 7'h00;
  localparam logic [4:0]  FACTOR_RESET    = 5'h00;
  localparam int          SAMPLE_CYCLES   = 2;

  typedef enum logic [1:0] {
    CMRD_IDLE,
    CMRD_SAMPLE,
    CMRD_HOLD
  } cmrd_state_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] commsFactor;
    logic [4:0] coreFactor;
    logic [4:0] divFactor;
  } cmrd_ratio_t;
endpackage

/* verilog/cmrd_host_table.sv */
// host mode ratio table for both range-select settings
`timescale 1ns/1ps
module cmrd_host_table
  import cmrd_pkg::*;
(
  // mode code
  input  wire logic [6:0] modeCode,
  // decoded ratios
  output cmrd_ratio_t     ratio
);
  function automatic cmrd_ratio_t mk(input logic [4:0] c,
                                     input logic [4:0] k,
                                     input logic [4:0] d);
    mk.valid       = 1'b1;
    mk.commsFactor = c;
    mk.coreFactor  = k;
    mk.divFactor   = d;
  endfunction

  always_comb
  begin
    ratio = '0;
    if (modeCode >= 7'h21 && modeCode <= 7'h23)
      ratio = mk(5'h0C, 5'(5'h0C + 2 * (modeCode - 7'h21)), 5'h0C);
    else if (modeCode >= 7'h28 && modeCode <= 7'h2C)
      ratio = mk(5'h04, 5'(5'h05 + (modeCode - 7'h28)), 5'h08);
    else if (modeCode >= 7'h2D && modeCode <= 7'h2F)
      ratio = mk(5'h06, 5'(5'h07 + (modeCode - 7'h2D)), 5'h0A);
    else if (modeCode >= 7'h30 && modeCode <= 7'h35)
      ratio = mk(5'h05, 5'(5'h05 + (modeCode - 7'h30)), 5'h0C);
    else if (modeCode == 7'h36)
      ratio = mk(5'h05, 5'h0C, 5'h0C);
    else if (modeCode >= 7'h39 && modeCode <= 7'h3C)
      ratio = mk(5'h06, 5'(5'h06 + (modeCode - 7'h39)), 5'h0C);
    else if (modeCode == 7'h41)
      ratio = mk(5'h06, 5'h06, 5'h10);
  end
endmodule

/* verilog/cmrd_agent_table.sv */
// agent mode ratio table for both range-select settings
`timescale 1ns/1ps
module cmrd_agent_table
  import cmrd_pkg::*;
(
  // mode code
  input  wire logic [6:0] modeCode,
  // decoded ratios
  output cmrd_ratio_t     ratio
);
  function automatic cmrd_ratio_t mk(input logic [4:0] c,
                                     input logic [4:0] k,
                                     input logic [4:0] d);
    mk.valid       = 1'b1;
    mk.commsFactor = c;
    mk.coreFactor  = k;
    mk.divFactor   = d;
  endfunction

  always_comb
  begin
    ratio = '0;
    case (modeCode)
      7'h00: ratio = mk(5'h04, 5'h05, 5'h04);
      7'h01: ratio = mk(5'h04, 5'h06, 5'h04);
      7'h02: ratio = mk(5'h06, 5'h06, 5'h06);
      7'h03: ratio = mk(5'h06, 5'h08, 5'h06);
      7'h04: ratio = mk(5'h06, 5'h06, 5'h05);
      7'h05: ratio = mk(5'h06, 5'h07, 5'h05);
      7'h06: ratio = mk(5'h08, 5'h07, 5'h06);
      7'h07: ratio = mk(5'h08, 5'h06, 5'h05);
      default: ratio = '0;
    endcase
    if (modeCode >= 7'h09 && modeCode <= 7'h0C)
      ratio = mk(5'h04, 5'(5'h0A + 2 * (modeCode - 7'h09)), 5'h08);
    else if (modeCode >= 7'h11 && modeCode <= 7'h14)
      ratio = mk(5'h06, 5'(5'h06 + (modeCode - 7'h11)), 5'h05);
    else if (modeCode >= 7'h70 && modeCode <= 7'h73)
      ratio = mk(5'h0A, 5'(5'h05 + (modeCode - 7'h70)), 5'h04);
    else if (modeCode >= 7'h74 && modeCode <= 7'h77)
      ratio = mk(5'h0A, 5'(5'h08 + (modeCode - 7'h74)), 5'h06);
    else if (modeCode >= 7'h60 && modeCode <= 7'h62)
      ratio = '0;
  end
endmodule

/* verilog/cmrd_clock_mode_ratio_decoder.sv */
// top: samples the clock mode at hard reset and holds decoded ratios
//
// Functional notes
// - mode code: config word bits 28-31 high, three strap pins low
// - comms factor equals comms clock over system bus clock
// - core factor drives the core PLL multiplier
// - agent mode takes the PCI clock as reference input clock
// - high range divider code 3,5,7,9,B gives ratio 4,6,8,5,6
// - range-select bit picks between the two mode tables
// - agent high table codes 1100_000 to 1100_010 are reserved
// - agent default modes 0000_xxx factors per fixed list
// - agent 0001_001..100: comms 2, core 5 to 8, bus div 4
// - agent 0010_001..100: comms 3, core 3 to 4.5, div 2.5
// - agent 1110_xxx: comms 5, core list, div 2 then 3
// - host 0100_001..011: comms 6, core 6 to 8, PCI div 6
// - host 0101_xxx: comms 2 div 4, then comms 3 div 5
// - host 0110_000..110: comms 2.5, core list, PCI div 6
// - host high: 0111_000, 1000_000 reserved; others listed
`timescale 1ns/1ps
module cmrd_clock_mode_ratio_decoder
  import cmrd_pkg::*;
#(
  parameter int SAMPLE_HOLD = SAMPLE_CYCLES
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // hard reset sampling
  input  wire logic                  hardResetActive,
  input  wire logic [CFG_WORD_W-1:0] resetConfigWord,
  input  wire logic [2:0]            mode_strap_pins,
  input  wire logic                  pci_range_select,
  input  wire logic                  pciAgentMode,
  // decoded clock configuration, factors in half units
  output logic [6:0]                 modeCode,
  output logic [4:0]                 commsFactor,
  output logic [4:0]                 coreFactor,
  output logic [4:0]                 pciDivFactor,
  output logic [4:0]                 busDivFactor,
  output logic [3:0]                 pci_divider_code,
  output logic                       refFromPciClock,
  output logic                       configValid,
  output logic                       configInvalid
);
  // hold count must fit the four-bit counter
  if (SAMPLE_HOLD < 1 || SAMPLE_HOLD > 15)
  begin : gHoldRange
    $error("SAMPLE_HOLD out of range");
  end

  cmrd_state_t state;
  logic [3:0]  holdCount;
  logic [6:0]  sampledMode;
  logic        sampledRange;
  logic        sampledAgent;
  cmrd_ratio_t hostLow;
  cmrd_ratio_t hostHigh;
  cmrd_ratio_t agentLow;
  cmrd_ratio_t agentHigh;
  cmrd_ratio_t next_ratio;

  cmrd_host_table uHost
  (
    .modeCode (sampledMode),
    .ratio    (hostLow)
  );

  cmrd_agent_table uAgent
  (
    .modeCode (sampledMode),
    .ratio    (agentLow)
  );

  // range-select high reuses the same decoded entries, reserved removed
  always_comb
  begin
    hostHigh  = hostLow;
    agentHigh = agentLow;
    if (sampledMode == 7'h38 || sampledMode == 7'h40)
      hostHigh = '0;
    if (sampledMode >= 7'h60 && sampledMode <= 7'h62)
      agentHigh = '0;
  end

  // table select by role and range bit
  always_comb
  begin
    if (sampledAgent)
      next_ratio = sampledRange ? agentHigh : agentLow;
    else
      next_ratio = sampledRange ? hostHigh : hostLow;
  end

  // sampling sequence: capture during hard reset, settle, then hold
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state        <= CMRD_IDLE;
      holdCount    <= 4'h0;
      sampledMode  <= MODE_RESET;
      sampledRange <= 1'b0;
      sampledAgent <= 1'b0;
    end
    else
    begin
      case (state)
        CMRD_IDLE:
        begin
          if (hardResetActive)
          begin
            sampledMode  <= {resetConfigWord[NIBBLE_MSB:NIBBLE_LSB],
                             mode_strap_pins};
            sampledRange <= pci_range_select;
            sampledAgent <= pciAgentMode;
            holdCount    <= 4'h0;
            state        <= CMRD_SAMPLE;
          end
        end
        CMRD_SAMPLE:
        begin
          if (hardResetActive)
          begin
            sampledMode  <= {resetConfigWord[NIBBLE_MSB:NIBBLE_LSB],
                             mode_strap_pins};
            sampledRange <= pci_range_select;
            sampledAgent <= pciAgentMode;
            holdCount    <= 4'h0;
          end
          else if (holdCount == 4'(SAMPLE_HOLD - 1))
            state <= CMRD_HOLD;
          else
            holdCount <= holdCount + 4'h1;
        end
        CMRD_HOLD:
        begin
          // a one-cycle hard reset must not be lost here
          if (hardResetActive)
          begin
            sampledMode  <= {resetConfigWord[NIBBLE_MSB:NIBBLE_LSB],
                             mode_strap_pins};
            sampledRange <= pci_range_select;
            sampledAgent <= pciAgentMode;
            holdCount    <= 4'h0;
            state        <= CMRD_SAMPLE;
          end
        end
        default: state <= CMRD_IDLE;
      endcase
    end
  end

  // decoded outputs, registered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      modeCode        <= MODE_RESET;
      commsFactor     <= FACTOR_RESET;
      coreFactor      <= FACTOR_RESET;
      pciDivFactor    <= FACTOR_RESET;
      busDivFactor    <= FACTOR_RESET;
      pci_divider_code <= 4'h0;
      refFromPciClock <= 1'b0;
      configValid     <= 1'b0;
      configInvalid   <= 1'b0;
    end
    else if (state == CMRD_SAMPLE && !hardResetActive &&
             holdCount == 4'(SAMPLE_HOLD - 1))
    begin
      modeCode        <= sampledMode;
      commsFactor     <= next_ratio.commsFactor;
      coreFactor      <= next_ratio.coreFactor;
      refFromPciClock <= sampledAgent;
      configValid     <= next_ratio.valid;
      configInvalid   <= !next_ratio.valid;
      if (sampledAgent)
      begin
        busDivFactor     <= next_ratio.divFactor;
        pciDivFactor     <= FACTOR_RESET;
        pci_divider_code <= 4'h0;
      end
      else
      begin
        pciDivFactor <= next_ratio.divFactor;
        busDivFactor <= FACTOR_RESET;
        // divider code whose ratio matches the PCI division factor
        if (!sampledRange)
          pci_divider_code <= 4'(next_ratio.divFactor[4:1] - 4'h1);
        else
          case (next_ratio.divFactor)
            5'h08:   pci_divider_code <= 4'h3;
            5'h0A:   pci_divider_code <= 4'h9;
            5'h0C:   pci_divider_code <= 4'h5;
            5'h10:   pci_divider_code <= 4'h7;
            default: pci_divider_code <= 4'h0;
          endcase
      end
    end
    else if ((state == CMRD_IDLE || state == CMRD_HOLD) && hardResetActive)
    begin
      configValid   <= 1'b0;
      configInvalid <= 1'b0;
    end
  end
endmodule

/* testbench/cmrd_assertions.sv */
// checker: port relations of the clock mode ratio decoder
`timescale 1ns/1ps
module cmrd_checker
#(
  parameter int SAMPLE_HOLD = 2
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // sampled inputs
  input wire logic        hardResetActive,
  input wire logic [31:0] resetConfigWord,
  input wire logic [2:0]  mode_strap_pins,
  input wire logic        pci_range_select,
  input wire logic        pciAgentMode,
  // decoded outputs
  input wire logic [6:0]  modeCode,
  input wire logic [4:0]  pciDivFactor,
  input wire logic [4:0]  busDivFactor,
  input wire logic        refFromPciClock,
  input wire logic        configValid,
  input wire logic        configInvalid
);
  localparam int LAT  = SAMPLE_HOLD;
  localparam int LAT1 = SAMPLE_HOLD - 1;
  logic [8:0] cap;
  logic       done;
  logic       rsv;
  assign done = configValid | configInvalid;
  assign rsv  = cap[7] ? (cap[6:0] inside {7'h60, 7'h61, 7'h62})
                       : (cap[6:0] inside {7'h38, 7'h40});
  // last inputs seen while hard reset is held
  always_ff @(posedge clk)
  begin
    if (hardResetActive)
      cap <= {pci_range_select, pciAgentMode, resetConfigWord[31:28],
              mode_strap_pins};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_mode_capture: assert property ($fell(hardResetActive) |-> ##LAT
    modeCode == cap[6:0]) else $error("mode code differs from capture");
  a_result_excl: assert property (!(configValid && configInvalid))
    else $error("valid and invalid both set");
  a_clear_on_hard: assert property ($rose(hardResetActive) |=> !done)
    else $error("result not cleared by hard reset");
  a_answer_time: assert property ($fell(hardResetActive) |->
    !done ##LAT1 !done ##1 done) else $error("result not on time");
  a_ref_agent: assert property (configValid |->
    refFromPciClock == cap[7]) else $error("reference select wrong");
  a_host_div: assert property (configValid && !cap[7] |->
    busDivFactor == 5'h00 && pciDivFactor != 5'h00)
    else $error("host division factors wrong");
  a_agent_div: assert property (configValid && cap[7] |->
    pciDivFactor == 5'h00 && busDivFactor != 5'h00)
    else $error("agent division factors wrong");
  a_reserved_flag: assert property (done && cap[8] && rsv |->
    configInvalid) else $error("reserved mode not flagged");
  c_host: cover property (configValid && !cap[7]);
  c_agent: cover property (configValid && cap[7]);
  c_rsv: cover property (configInvalid && rsv);
endmodule

bind cmrd_clock_mode_ratio_decoder cmrd_checker #(
  .SAMPLE_HOLD(SAMPLE_HOLD)
) u_cmrd_checker (
  .clk(clk), .rst_n(rst_n), .hardResetActive(hardResetActive),
  .resetConfigWord(resetConfigWord), .mode_strap_pins(mode_strap_pins),
  .pci_range_select(pci_range_select), .pciAgentMode(pciAgentMode),
  .modeCode(modeCode), .pciDivFactor(pciDivFactor),
  .busDivFactor(busDivFactor), .refFromPciClock(refFromPciClock),
  .configValid(configValid), .configInvalid(configInvalid));

/* testbench/cmrd_strap_source.sv */
// model: board strap pins and reset configuration word source
`timescale 1ns/1ps
module cmrd_strap_source
(
  // bench control
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] cfg,
  input  wire logic       rngSel,
  input  wire logic [1:0] pulseLen,
  // straps and configuration word
  output logic            hardResetActive,
  output logic [31:0]     resetConfigWord,
  output logic [2:0]      mode_strap_pins,
  output logic            pci_range_select,
  output logic            pciAgentMode
);
  logic [2:0] cnt;
  initial
  begin
    cnt              = 3'h0;
    hardResetActive  = 1'h0;
    resetConfigWord  = 32'h5A5A5A5A;
    mode_strap_pins  = 3'h5;
    pci_range_select = 1'h0;
    pciAgentMode     = 1'h1;
  end
  always @(negedge clk)
  begin
    if (start && cnt == 3'h0)
    begin
      hardResetActive  <= 1'h1;
      resetConfigWord  <= {cfg[6:3], ~resetConfigWord[27:0]};
      mode_strap_pins  <= cfg[2:0];
      pci_range_select <= rngSel;
      pciAgentMode     <= cfg[7];
      cnt              <= {1'h0, pulseLen} + 3'h1;
    end
    else if (cnt > 3'h1)
      cnt <= cnt - 3'h1;
    else
    begin
      // straps not held: values keep changing
      hardResetActive  <= 1'h0;
      cnt              <= 3'h0;
      resetConfigWord  <= ~resetConfigWord;
      mode_strap_pins  <= ~mode_strap_pins;
      pci_range_select <= ~pci_range_select;
      pciAgentMode     <= ~pciAgentMode;
    end
  end
endmodule

/* testbench/cmrd_clock_mode_ratio_decoder_tb_top.sv */
// testbench: clock mode decodes through the strap model
`timescale 1ns/1ps
module cmrd_clock_mode_ratio_decoder_tb_top;
  // {agent, mode}, comms, core, division in half units
  localparam logic [31:0] TBL [25] = '{
    32'h210C0C0C, 32'h230C100C,
    32'h28040508, 32'h2C040908, 32'h2D06070A,
    32'h36050C0C, 32'h3906060C, 32'h3C06090C, 32'h41060610,
    32'h80040504, 32'h87080605, 32'h84060605,
    32'h89040A08, 32'h8C041008, 32'h91060605, 32'h94060905,
    32'hF00A0504, 32'hF30A0804, 32'hF40A0806, 32'hF70A0B06,
    32'h38000000, 32'h40000000, 32'hE0000000, 32'hE1000000,
    32'hE2000000};
  logic        clk, rst_n, start, rngSel, hra, agt, rng, cv, ci, refPci;
  logic        prevDone;
  logic [1:0]  pulseLen;
  logic [2:0]  straps;
  logic [3:0]  dcode, dx;
  logic [4:0]  cf, kf, pf, bf;
  logic [6:0]  mode;
  logic [7:0]  cfg;
  logic [31:0] cw;
  logic [32:0] exq[$];
  logic [32:0] cur;
  int          seed = 52902;
  int          errorCnt = 0;
  int          numChecks = 0;
  int          cyc = 0;

  cmrd_strap_source u_cmrd_strap_source (
    .clk(clk), .start(start), .cfg(cfg), .rngSel(rngSel),
    .pulseLen(pulseLen), .hardResetActive(hra), .resetConfigWord(cw),
    .mode_strap_pins(straps), .pci_range_select(rng), .pciAgentMode(agt));
  cmrd_clock_mode_ratio_decoder #(
    .SAMPLE_HOLD(2)
  ) u_cmrd_clock_mode_ratio_decoder (
    .clk(clk), .rst_n(rst_n), .hardResetActive(hra),
    .resetConfigWord(cw), .mode_strap_pins(straps),
    .pci_range_select(rng), .pciAgentMode(agt), .modeCode(mode),
    .commsFactor(cf), .coreFactor(kf), .pciDivFactor(pf),
    .busDivFactor(bf), .pci_divider_code(dcode),
    .refFromPciClock(refPci), .configValid(cv), .configInvalid(ci));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= 3000)
    begin
      errorCnt++;
      finalReport();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    numChecks++;
    if (s !== x)
    begin
      errorCnt++;
      $display("MISMATCH %s exp %h seen %h", nm, x, s);
    end
  endtask

  task automatic ratios(input string nm, input logic [32:0] e);
    logic [31:0] sv;
    logic [31:0] xv;
    sv = {cv, ci, refPci, mode, cf, kf, pf, bf, 2'h0};
    xv = {2'h2, e[31], e[30:24], e[20:16], e[12:8],
          e[31] ? 5'h00 : e[4:0], e[31] ? e[4:0] : 5'h00, 2'h0};
    if (e[23:16] == 8'h00)
    begin
      sv = sv & 32'hDFC00000;
      xv = {2'h1, 1'h0, e[30:24], 22'h0};
    end
    chk(nm, sv, xv);
  endtask

  // result watcher: oldest note against each new result
  always @(negedge clk)
  begin
    if ((cv === 1'h1 || ci === 1'h1) && !prevDone && exq.size() > 0)
    begin
      cur = exq.pop_front();
      ratios("ratios", cur);
      dx = (cur[4:0] == 5'h08) ? 4'h3 : (cur[4:0] == 5'h0A) ? 4'h9 :
           (cur[4:0] == 5'h0C) ? 4'h5 : 4'h7;
      if (!cur[32])
        dx = 4'(cur[4:1] - 4'h1);
      if (cur[31])
        dx = 4'h0;
      if (cur[23:16] != 8'h00)
        chk("divcode", {28'h0, dcode}, {28'h0, dx});
    end
    prevDone = (cv === 1'h1 || ci === 1'h1);
  end

  task automatic decode(input logic [31:0] ent);
    logic [32:0] e;
    @(negedge clk);
    e = {1'($random(seed)) | (ent[23:16] == 8'h00), ent};
    cfg <= ent[31:24];
    rngSel <= e[32];
    pulseLen <= 2'($random(seed));
    start <= 1'h1;
    exq.push_back(e);
    @(negedge clk);
    start <= 1'h0;
    while (exq.size() != 0)
      @(negedge clk);
    repeat (4) @(negedge clk);
    ratios("hold", e);
  endtask

  initial
  begin
    rst_n = 1'h0;
    start = 1'h0;
    cfg = 8'h00;
    rngSel = 1'h0;
    pulseLen = 2'h0;
    prevDone = 1'h0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
      begin
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        chk("reset", {2'h0, cv, ci, refPci, mode, cf, kf, pf, bf},
            32'h0);
        chk("resetcode", {28'h0, dcode}, 32'h0);
        rst_n = 1'h1;
        $display("reset test done");
      end
      foreach (TBL[i])
        decode(TBL[i]);
      $display("table pass %0d done", p);
    end
    finalReport();
  end
endmodule
